// ### verilog/sdc_defs.vh
// Offsets, fields, reset values and codes of the SDRAM controller
`ifndef SDC_DEFS_VH
`define SDC_DEFS_VH
`define SDC_OFF_MODE 8'h00
`define SDC_OFF_REFRESH 8'h04
`define SDC_OFF_CONFIG 8'h08
`define SDC_OFF_LOWPWR 8'h10
`define SDC_OFF_IRQ_EN 8'h14
`define SDC_OFF_IRQ_DIS 8'h18
`define SDC_OFF_IRQ_MASK 8'h1c
`define SDC_OFF_IRQ_STAT 8'h20
`define SDC_RST_MODE 32'h00000000
`define SDC_RST_REFRESH 32'h00000000
`define SDC_RST_CONFIG 32'h00072240
`define SDC_RST_LOWPWR 32'h00000000
`define SDC_MODE_LSB 0
`define SDC_REF_LSB 0
`define SDC_CFG_COL_LSB 0
`define SDC_CFG_ROW_LSB 2
`define SDC_CFG_DBW_BIT 4
`define SDC_CFG_CAS_LSB 5
`define SDC_CFG_TRP_LSB 8
`define SDC_CFG_TRCD_LSB 12
`define SDC_CFG_TRC_LSB 16
`define SDC_LP_PARTIAL_ARRAY_REFRESH_LSB 0
`define SDC_LP_TEMP_COMP_SELF_REFRESH_LSB 4
`define SDC_LP_DS_LSB 6
`define SDC_MODE_NORMAL 3'h0
`define SDC_MODE_NOP 3'h1
`define SDC_MODE_PALL 3'h2
`define SDC_MODE_LMR 3'h3
`define SDC_MODE_AREF 3'h4
`define SDC_MODE_EXT_LMR 3'h5
`define SDC_PIN_NOP 3'h7
`define SDC_PIN_ACT 3'h3
`define SDC_PIN_READ 3'h5
`define SDC_PIN_WRITE 3'h4
`define SDC_PIN_PRE 3'h2
`define SDC_PIN_REF 3'h1
`define SDC_PIN_LMR 3'h0
`define SDC_WRITE_RECOVERY 4'h2
`define SDC_RESP_OKAY 2'h0
`define SDC_RESP_SLVERR 2'h2
`endif

// ### verilog/sdc_axil_regs.v
// AXI4-Lite register slave of the SDRAM controller
`timescale 1ns/1ps
`include "sdc_defs.vh"
module sdc_axil_regs (
  input wire clk,
  input wire rst,
  input wire [7:0] awaddr,
  input wire awvalid,
  output reg awready,
  input wire [31:0] wdata,
  input wire [3:0] wstrb,
  input wire wvalid,
  output reg wready,
  output reg [1:0] bresp,
  output reg bvalid,
  input wire bready,
  input wire [7:0] araddr,
  input wire arvalid,
  output reg arready,
  output reg [31:0] rdata,
  output reg [1:0] rresp,
  output reg rvalid,
  input wire rready,
  input wire refresh_err,
  output reg [31:0] mode_q,
  output reg [31:0] refresh_q,
  output reg [31:0] config_q,
  output reg [31:0] lowpwr_q,
  output wire irq
);
  reg [7:0] aw_addr_q;
  reg aw_got_q;
  reg [31:0] w_data_q;
  reg [3:0] w_strb_q;
  reg w_got_q;
  reg mask_q;
  reg stat_q;
  wire do_write;
  wire do_read;
  wire stat_read;

  function [31:0] merge;
    input [31:0] old;
    input [31:0] nw;
    input [3:0] strb;
    integer i;
    begin
      for (i = 0; i < 4; i = i + 1)
        merge[i*8 +: 8] = strb[i] ? nw[i*8 +: 8] : old[i*8 +: 8];
    end
  endfunction

  function mapped;
    input [7:0] a;
    begin
      mapped = (a == `SDC_OFF_MODE) || (a == `SDC_OFF_REFRESH) || (a == `SDC_OFF_CONFIG) ||
        (a == `SDC_OFF_LOWPWR) || (a == `SDC_OFF_IRQ_EN) || (a == `SDC_OFF_IRQ_DIS) ||
        (a == `SDC_OFF_IRQ_MASK) || (a == `SDC_OFF_IRQ_STAT);
    end
  endfunction

  assign do_write = aw_got_q && w_got_q && !bvalid;
  assign do_read = arvalid && arready;
  assign stat_read = do_read && (araddr == `SDC_OFF_IRQ_STAT);
  assign irq = stat_q && mask_q;

  // ----------------------------------------
  // Write channels
  // ----------------------------------------
  always @(posedge clk)
  begin
    if (rst)
    begin
      awready <= 1'b1;
      wready <= 1'b1;
      aw_got_q <= 1'b0;
      w_got_q <= 1'b0;
      aw_addr_q <= 8'h00;
      w_data_q <= 32'h00000000;
      w_strb_q <= 4'h0;
      bvalid <= 1'b0;
      bresp <= `SDC_RESP_OKAY;
      mode_q <= `SDC_RST_MODE;
      refresh_q <= `SDC_RST_REFRESH;
      config_q <= `SDC_RST_CONFIG;
      lowpwr_q <= `SDC_RST_LOWPWR;
      mask_q <= 1'b0;
    end
    else
    begin
      if (awvalid && awready)
      begin
        aw_addr_q <= awaddr;
        aw_got_q <= 1'b1;
        awready <= 1'b0;
      end
      if (wvalid && wready)
      begin
        w_data_q <= wdata;
        w_strb_q <= wstrb;
        w_got_q <= 1'b1;
        wready <= 1'b0;
      end
      if (do_write)
      begin
        bvalid <= 1'b1;
        bresp <= mapped(aw_addr_q) ? `SDC_RESP_OKAY : `SDC_RESP_SLVERR;
        case (aw_addr_q)
          `SDC_OFF_MODE: mode_q <= merge(mode_q, w_data_q, w_strb_q) & 32'h00000007;
          `SDC_OFF_REFRESH: refresh_q <= merge(refresh_q, w_data_q, w_strb_q) & 32'h00000fff;
          `SDC_OFF_CONFIG: config_q <= merge(config_q, w_data_q, w_strb_q) & 32'h000fff7f;
          `SDC_OFF_LOWPWR: lowpwr_q <= merge(lowpwr_q, w_data_q, w_strb_q) & 32'h000000f7;
          `SDC_OFF_IRQ_EN: if (w_strb_q[0] && w_data_q[0]) mask_q <= 1'b1;
          `SDC_OFF_IRQ_DIS: if (w_strb_q[0] && w_data_q[0]) mask_q <= 1'b0;
          default: mask_q <= mask_q;
        endcase
      end
      if (bvalid && bready)
      begin
        bvalid <= 1'b0;
        aw_got_q <= 1'b0;
        w_got_q <= 1'b0;
        awready <= 1'b1;
        wready <= 1'b1;
      end
    end
  end

  // ----------------------------------------
  // Read channel and status flag
  // ----------------------------------------
  always @(posedge clk)
  begin
    if (rst)
    begin
      arready <= 1'b1;
      rvalid <= 1'b0;
      rdata <= 32'h00000000;
      rresp <= `SDC_RESP_OKAY;
      stat_q <= 1'b0;
    end
    else
    begin
      // R20: set wins clear
      if (refresh_err)
        stat_q <= 1'b1;
      else if (stat_read)
        stat_q <= 1'b0;
      if (do_read)
      begin
        arready <= 1'b0;
        rvalid <= 1'b1;
        rresp <= mapped(araddr) ? `SDC_RESP_OKAY : `SDC_RESP_SLVERR;
        case (araddr)
          `SDC_OFF_MODE: rdata <= mode_q;
          `SDC_OFF_REFRESH: rdata <= refresh_q;
          `SDC_OFF_CONFIG: rdata <= config_q;
          `SDC_OFF_LOWPWR: rdata <= lowpwr_q;
          `SDC_OFF_IRQ_MASK: rdata <= {31'h00000000, mask_q};
          `SDC_OFF_IRQ_STAT: rdata <= {31'h00000000, stat_q};
          default: rdata <= 32'h00000000;
        endcase
      end
      else if (rvalid && rready)
      begin
        rvalid <= 1'b0;
        arready <= 1'b1;
      end
    end
  end
endmodule // sdc_axil_regs

// ### verilog/sdc_core.v
// SDRAM controller top: request port, sequencer, pins, registers
// Functional notes
// R01: Memory data bus is 16 or 32 bits, chosen by configuration.
// R02: Columns per row selectable from 256 to 2048.
// R03: Byte, half-word and word accesses; masks enable only addressed bytes. Reads enable every bus lane.
// R04: Burst length of one; one column command per word.
// R05: Open row kept per bank; hit needs no activation.
// R06: CAS latency of one, two or three memory clocks.
// R07: Clock enable high; select, strobes, write enable and masks low.
// R08: 32-bit bus: byte bits 1:0, then column, row, two bank bits.
// R09: 16-bit bus: byte bit 0, then column, row, two bank bits.
// R10: Row field 11, 12 or 13 bits; upper bank bit drives bank 1.
// R11: Software configures, then waits 200 us before memory signals toggle.
// R12: Command field 1: memory write issues one NOP.
// R13: Command field 2: memory write issues precharge of all banks.
// R14: Command field 4: each write issues one auto-refresh; eight at init.
// R15: Command field 3, bank zero: load mode with CAS latency, burst one.
// R16: Command field 5, one bank bit set: extended mode load.
// R17: Command field 0 then one write returns to normal accesses.
// R18: Software loads refresh interval in controller clock cycles.
// R19: Refresh error ORed with other system interrupt lines.
// R20: Missed refresh raises error; reading status clears it.
// R21: Row miss: precharge, activate after delays, then column command.
// R22: Refresh timer reloads, refreshes on expiry, holds pending access with wait.
// R23: Non-zero command field: one command per write, no data transfer.
//
// Implementation choices: the AXI4-Lite slave port and the register offsets.
`timescale 1ns/1ps
`include "sdc_defs.vh"
module sdc_core (
  input wire CORE_CLK,
  input wire RST,
  input wire [7:0] S_AXI_AWADDR,
  input wire S_AXI_AWVALID,
  output wire S_AXI_AWREADY,
  input wire [31:0] S_AXI_WDATA,
  input wire [3:0] S_AXI_WSTRB,
  input wire S_AXI_WVALID,
  output wire S_AXI_WREADY,
  output wire [1:0] S_AXI_BRESP,
  output wire S_AXI_BVALID,
  input wire S_AXI_BREADY,
  input wire [7:0] S_AXI_ARADDR,
  input wire S_AXI_ARVALID,
  output wire S_AXI_ARREADY,
  output wire [31:0] S_AXI_RDATA,
  output wire [1:0] S_AXI_RRESP,
  output wire S_AXI_RVALID,
  input wire S_AXI_RREADY,
  input wire MEM_REQ,
  input wire MEM_WE,
  input wire [1:0] MEM_SIZE,
  input wire [27:0] MEM_ADDR,
  input wire [31:0] MEM_WDATA,
  output reg [31:0] MEM_RDATA,
  output reg MEM_ACK,
  output reg MEM_WAIT,
  input wire OTHER_IRQ,
  output reg SYS_IRQ,
  output reg MEM_CLOCK_OUT,
  output reg MEM_CLOCK_ENABLE,
  output reg MEM_CHIP_SELECT_N,
  output reg MEM_ROW_STROBE_N,
  output reg MEM_COL_STROBE_N,
  output reg MEM_WRITE_ENABLE_N,
  output reg [1:0] MEM_BANK,
  output reg [12:0] MEM_ADDR_BUS,
  output reg [3:0] BYTE_MASK_N,
  input wire [31:0] DQ_IN,
  output reg [31:0] DQ_OUT,
  output reg DQ_OE
);
  localparam S_IDLE = 4'h0;
  localparam S_PRE = 4'h1;
  localparam S_ACT = 4'h2;
  localparam S_COL = 4'h3;
  localparam S_RDW = 4'h4;
  localparam S_ACK = 4'h5;
  localparam S_REFP = 4'h6;
  localparam S_REF = 4'h7;
  localparam S_SPEC = 4'h8;
  localparam S_WAIT = 4'h9;

  wire [31:0] mode_w;
  wire [31:0] refresh_w;
  wire [31:0] config_w;
  wire [31:0] lowpwr_w;
  wire irq_w;
  reg refresh_err_q;
  reg phase_q;
  reg [3:0] state_q;
  reg [3:0] ret_q;
  reg [3:0] wait_q;
  reg [11:0] ref_cnt_q;
  reg ref_pend_q;
  reg [3:0] open_v_q;
  reg [12:0] open_row_q [0:3];
  reg [31:0] dq_s1_q;
  reg [31:0] dq_s2_q;
  reg [1:0] bank_q;
  reg [12:0] row_q;
  reg [10:0] col_q;
  reg we_q;
  reg [3:0] mask_q;
  reg [31:0] wdata_q;
  reg [2:0] cmd_mode_q;
  wire tick;
  wire dbw16;
  wire [1:0] cas;
  wire [25:0] split_w;
  integer i;

  assign tick = phase_q;
  assign dbw16 = config_w[`SDC_CFG_DBW_BIT];
  assign cas = config_w[`SDC_CFG_CAS_LSB +: 2];

  // R08: address split, R09 for 16-bit, R10 row width, R02 columns
  function [25:0] split_addr;
    input [27:0] a;
    input d16;
    input [1:0] colsel;
    input [1:0] rowsel;
    reg [27:0] s;
    reg [10:0] c_f;
    reg [12:0] r_f;
    integer c;
    integer r;
    begin
      c = 8 + colsel;
      r = 11 + rowsel;
      s = d16 ? (a >> 1) : (a >> 2);
      c_f = s[10:0] & ((11'h001 << c) - 11'h001);
      s = s >> c;
      r_f = s[12:0] & ((13'h0001 << r) - 13'h0001);
      s = s >> r;
      split_addr = {s[1:0], r_f, c_f};
    end
  endfunction

  // R03: lanes enabled per access size, R01 for bus width
  function [3:0] lane_mask;
    input [1:0] size;
    input [1:0] a;
    input d16;
    begin
      if (d16)
        lane_mask = (size == 2'h0) ? (a[0] ? 4'h2 : 4'h1) : 4'h3;
      else if (size == 2'h0)
        lane_mask = 4'h1 << a;
      else if (size == 2'h1)
        lane_mask = a[1] ? 4'hc : 4'h3;
      else
        lane_mask = 4'hf;
    end
  endfunction

  assign split_w = split_addr(MEM_ADDR, dbw16, config_w[`SDC_CFG_COL_LSB +: 2],
    config_w[`SDC_CFG_ROW_LSB +: 2]);

  sdc_axil_regs u_regs (
    .clk(CORE_CLK),
    .rst(RST),
    .awaddr(S_AXI_AWADDR),
    .awvalid(S_AXI_AWVALID),
    .awready(S_AXI_AWREADY),
    .wdata(S_AXI_WDATA),
    .wstrb(S_AXI_WSTRB),
    .wvalid(S_AXI_WVALID),
    .wready(S_AXI_WREADY),
    .bresp(S_AXI_BRESP),
    .bvalid(S_AXI_BVALID),
    .bready(S_AXI_BREADY),
    .araddr(S_AXI_ARADDR),
    .arvalid(S_AXI_ARVALID),
    .arready(S_AXI_ARREADY),
    .rdata(S_AXI_RDATA),
    .rresp(S_AXI_RRESP),
    .rvalid(S_AXI_RVALID),
    .rready(S_AXI_RREADY),
    .refresh_err(refresh_err_q),
    .mode_q(mode_w),
    .refresh_q(refresh_w),
    .config_q(config_w),
    .lowpwr_q(lowpwr_w),
    .irq(irq_w)
  );

  // ----------------------------------------
  // Clock divider, data sync, interrupt
  // ----------------------------------------
  always @(posedge CORE_CLK)
  begin
    if (RST)
    begin
      phase_q <= 1'b0;
      MEM_CLOCK_OUT <= 1'b0;
      MEM_CLOCK_ENABLE <= 1'b0;
      dq_s1_q <= 32'h00000000;
      dq_s2_q <= 32'h00000000;
      SYS_IRQ <= 1'b0;
    end
    else
    begin
      phase_q <= ~phase_q;
      MEM_CLOCK_OUT <= ~phase_q;
      // R07: clock enable active high
      MEM_CLOCK_ENABLE <= 1'b1;
      dq_s1_q <= DQ_IN;
      dq_s2_q <= dq_s1_q;
      // R19: combined system interrupt
      SYS_IRQ <= irq_w | OTHER_IRQ;
    end
  end

  // ----------------------------------------
  // Refresh timer
  // ----------------------------------------
  always @(posedge CORE_CLK)
  begin
    if (RST)
    begin
      ref_cnt_q <= 12'h000;
      ref_pend_q <= 1'b0;
      refresh_err_q <= 1'b0;
      MEM_WAIT <= 1'b0;
    end
    else
    begin
      refresh_err_q <= 1'b0;
      // R22: count down, reload, request refresh
      if (ref_cnt_q == 12'h000)
      begin
        ref_cnt_q <= refresh_w[`SDC_REF_LSB +: 12];
        if (refresh_w[`SDC_REF_LSB +: 12] != 12'h000)
        begin
          ref_pend_q <= 1'b1;
          // R20: previous refresh not performed
          if (ref_pend_q)
            refresh_err_q <= 1'b1;
        end
      end
      else
        ref_cnt_q <= ref_cnt_q - 12'h001;
      if (tick && state_q == S_IDLE && ref_pend_q)
        ref_pend_q <= 1'b0;
      // R22: wait while refresh owns the memory
      MEM_WAIT <= MEM_REQ && !MEM_ACK && state_q != S_ACK && (ref_pend_q || state_q == S_REFP ||
        state_q == S_REF || (state_q == S_WAIT && (ret_q == S_REF || ret_q == S_IDLE)));
    end
  end

  // ----------------------------------------
  // Command sequencer
  // ----------------------------------------
  always @(posedge CORE_CLK)
  begin
    if (RST)
    begin
      state_q <= S_IDLE;
      ret_q <= S_IDLE;
      wait_q <= 4'h0;
      open_v_q <= 4'h0;
      for (i = 0; i < 4; i = i + 1)
        open_row_q[i] <= 13'h0000;
      bank_q <= 2'h0;
      row_q <= 13'h0000;
      col_q <= 11'h000;
      we_q <= 1'b0;
      mask_q <= 4'h0;
      wdata_q <= 32'h00000000;
      cmd_mode_q <= `SDC_MODE_NORMAL;
      MEM_RDATA <= 32'h00000000;
      MEM_ACK <= 1'b0;
      MEM_CHIP_SELECT_N <= 1'b1;
      {MEM_ROW_STROBE_N, MEM_COL_STROBE_N, MEM_WRITE_ENABLE_N} <= `SDC_PIN_NOP;
      MEM_BANK <= 2'h0;
      MEM_ADDR_BUS <= 13'h0000;
      BYTE_MASK_N <= 4'hf;
      DQ_OUT <= 32'h00000000;
      DQ_OE <= 1'b0;
    end
    else
    begin
      MEM_ACK <= 1'b0;
      if (tick)
      begin
        // R07: chip select driven low, strobes and masks idle high, NOP by default
        MEM_CHIP_SELECT_N <= 1'b0;
        {MEM_ROW_STROBE_N, MEM_COL_STROBE_N, MEM_WRITE_ENABLE_N} <= `SDC_PIN_NOP;
        BYTE_MASK_N <= 4'hf;
        DQ_OE <= 1'b0;
        case (state_q)
          S_IDLE:
          begin
            if (ref_pend_q)
              state_q <= S_REFP;
            else if (MEM_REQ && !MEM_ACK)
            begin
              bank_q <= split_w[25:24];
              row_q <= split_w[23:11];
              col_q <= split_w[10:0];
              we_q <= MEM_WE;
              mask_q <= lane_mask(MEM_SIZE, MEM_ADDR[1:0], dbw16);
              wdata_q <= (dbw16 && MEM_ADDR[1]) ? {16'h0000, MEM_WDATA[31:16]} : MEM_WDATA;
              cmd_mode_q <= mode_w[`SDC_MODE_LSB +: 3];
              // R23, R17: write with non-zero mode bypasses array
              if (MEM_WE && mode_w[`SDC_MODE_LSB +: 3] != `SDC_MODE_NORMAL)
                state_q <= S_SPEC;
              // R05: row hit goes straight to column
              else if (open_v_q[split_w[25:24]] && open_row_q[split_w[25:24]] == split_w[23:11])
                state_q <= S_COL;
              else if (open_v_q[split_w[25:24]])
                state_q <= S_PRE;
              else
                state_q <= S_ACT;
            end
          end
          S_PRE:
          begin
            // R21: close other row
            {MEM_ROW_STROBE_N, MEM_COL_STROBE_N, MEM_WRITE_ENABLE_N} <= `SDC_PIN_PRE;
            MEM_BANK <= bank_q;
            MEM_ADDR_BUS <= 13'h0000;
            open_v_q[bank_q] <= 1'b0;
            wait_q <= config_w[`SDC_CFG_TRP_LSB +: 4];
            ret_q <= S_ACT;
            state_q <= S_WAIT;
          end
          S_ACT:
          begin
            // R21: activate after precharge delay
            {MEM_ROW_STROBE_N, MEM_COL_STROBE_N, MEM_WRITE_ENABLE_N} <= `SDC_PIN_ACT;
            // R10: bank bits onto bank pins
            MEM_BANK <= bank_q;
            MEM_ADDR_BUS <= row_q;
            open_v_q[bank_q] <= 1'b1;
            open_row_q[bank_q] <= row_q;
            wait_q <= config_w[`SDC_CFG_TRCD_LSB +: 4];
            ret_q <= S_COL;
            state_q <= S_WAIT;
          end
          S_COL:
          begin
            // R04: one column command per word, no auto precharge
            MEM_BANK <= bank_q;
            MEM_ADDR_BUS <= {1'b0, col_q[10], 1'b0, col_q[9:0]};
            if (we_q)
            begin
              {MEM_ROW_STROBE_N, MEM_COL_STROBE_N, MEM_WRITE_ENABLE_N} <= `SDC_PIN_WRITE;
              // R03: write only addressed bytes
              BYTE_MASK_N <= ~mask_q;
              DQ_OUT <= wdata_q;
              DQ_OE <= 1'b1;
              wait_q <= `SDC_WRITE_RECOVERY;
              ret_q <= S_ACK;
            end
            else
            begin
              {MEM_ROW_STROBE_N, MEM_COL_STROBE_N, MEM_WRITE_ENABLE_N} <= `SDC_PIN_READ;
              BYTE_MASK_N <= dbw16 ? 4'hc : 4'h0;
              // R06: wait the CAS latency plus sync
              wait_q <= {2'h0, cas} + 4'h1;
              ret_q <= S_RDW;
            end
            state_q <= S_WAIT;
          end
          S_RDW:
          begin
            MEM_RDATA <= dbw16 ? {dq_s2_q[15:0], dq_s2_q[15:0]} : dq_s2_q;
            state_q <= S_ACK;
          end
          S_ACK:
          begin
            MEM_ACK <= 1'b1;
            state_q <= S_IDLE;
          end
          S_REFP:
          begin
            // R22: precharge all ahead of refresh
            {MEM_ROW_STROBE_N, MEM_COL_STROBE_N, MEM_WRITE_ENABLE_N} <= `SDC_PIN_PRE;
            MEM_ADDR_BUS <= 13'h0400;
            open_v_q <= 4'h0;
            wait_q <= config_w[`SDC_CFG_TRP_LSB +: 4];
            ret_q <= S_REF;
            state_q <= S_WAIT;
          end
          S_REF:
          begin
            // R22: one timed auto-refresh
            {MEM_ROW_STROBE_N, MEM_COL_STROBE_N, MEM_WRITE_ENABLE_N} <= `SDC_PIN_REF;
            wait_q <= config_w[`SDC_CFG_TRC_LSB +: 4];
            ret_q <= S_IDLE;
            state_q <= S_WAIT;
          end
          S_SPEC:
          begin
            case (cmd_mode_q)
              // R12: single NOP
              `SDC_MODE_NOP:
                {MEM_ROW_STROBE_N, MEM_COL_STROBE_N, MEM_WRITE_ENABLE_N} <= `SDC_PIN_NOP;
              // R13: precharge all banks
              `SDC_MODE_PALL:
              begin
                {MEM_ROW_STROBE_N, MEM_COL_STROBE_N, MEM_WRITE_ENABLE_N} <= `SDC_PIN_PRE;
                MEM_ADDR_BUS <= 13'h0400;
                open_v_q <= 4'h0;
              end
              // R14: one auto-refresh per write
              `SDC_MODE_AREF:
                {MEM_ROW_STROBE_N, MEM_COL_STROBE_N, MEM_WRITE_ENABLE_N} <= `SDC_PIN_REF;
              // R15: mode load, burst one, CAS latency
              `SDC_MODE_LMR:
                if (bank_q == 2'h0)
                begin
                  {MEM_ROW_STROBE_N, MEM_COL_STROBE_N, MEM_WRITE_ENABLE_N} <= `SDC_PIN_LMR;
                  MEM_BANK <= 2'h0;
                  MEM_ADDR_BUS <= {6'h00, 1'b0, cas, 4'h0};
                end
              // R16: extended mode load for mobile parts
              `SDC_MODE_EXT_LMR:
                if (bank_q == 2'h1 || bank_q == 2'h2)
                begin
                  {MEM_ROW_STROBE_N, MEM_COL_STROBE_N, MEM_WRITE_ENABLE_N} <= `SDC_PIN_LMR;
                  MEM_BANK <= bank_q;
                  MEM_ADDR_BUS <= {6'h00, lowpwr_w[`SDC_LP_DS_LSB +: 2],
                    lowpwr_w[`SDC_LP_TEMP_COMP_SELF_REFRESH_LSB +: 2], lowpwr_w[`SDC_LP_PARTIAL_ARRAY_REFRESH_LSB +: 3]};
                end
              default:
                MEM_CHIP_SELECT_N <= 1'b0;
            endcase
            wait_q <= config_w[`SDC_CFG_TRC_LSB +: 4];
            ret_q <= S_ACK;
            state_q <= S_WAIT;
          end
          S_WAIT:
          begin
            if (wait_q <= 4'h1)
              state_q <= ret_q;
            else
              wait_q <= wait_q - 4'h1;
          end
          default:
            state_q <= S_IDLE;
        endcase
      end
    end
  end
endmodule // sdc_core

// ### testbench/sdc_core_asserts.sv
// Assertions on SDRAM controller core pins
`timescale 1ns/1ps
module sdc_core_asserts (
  input logic CORE_CLK,
  input logic RST,
  input logic MEM_ACK,
  input logic MEM_WAIT,
  input logic OTHER_IRQ,
  input logic SYS_IRQ,
  input logic MEM_CLOCK_ENABLE,
  input logic MEM_CHIP_SELECT_N,
  input logic MEM_ROW_STROBE_N,
  input logic MEM_COL_STROBE_N,
  input logic MEM_WRITE_ENABLE_N,
  input logic [3:0] BYTE_MASK_N,
  input logic DQ_OE
);
  // ----
  // Checks
  // ----
  default clocking cb @(posedge CORE_CLK);
  endclocking
  default disable iff (RST);
  sequence s_cmd(r, c, w);
    !MEM_CHIP_SELECT_N && MEM_ROW_STROBE_N == r && MEM_COL_STROBE_N == c
      && MEM_WRITE_ENABLE_N == w;
  endsequence
  a_cke_high: assert property (!$past(RST) |-> MEM_CLOCK_ENABLE)
    else $error("cke low");
  a_irq_merge: assert property (OTHER_IRQ |=> SYS_IRQ)
    else $error("irq not merged");
  a_ack_pulse: assert property (MEM_ACK |=> !MEM_ACK)
    else $error("ack too long");
  a_rd_mask: assert property (s_cmd(1, 0, 1) |-> BYTE_MASK_N == 4'h0)
    else $error("read masked");
  a_wr_drive: assert property (s_cmd(1, 0, 0) |-> DQ_OE)
    else $error("write undriven");
  a_rd_float: assert property (s_cmd(1, 0, 1) |-> !DQ_OE)
    else $error("read driven");
  a_wait_noack: assert property (MEM_WAIT |-> !MEM_ACK)
    else $error("ack while wait");
  a_act_gap: assert property (s_cmd(0, 1, 1) |=> MEM_COL_STROBE_N [*3])
    else $error("column too soon");
endmodule // sdc_core_asserts

// ### testbench/sdc_sdram_model.sv
// SDRAM device model
`timescale 1ns/1ps
module sdc_sdram_model #(
  parameter int CL = 2
) (
  input logic clk,
  input logic sclk,
  input logic cs_n,
  input logic ras_n,
  input logic cas_n,
  input logic we_n,
  input logic [1:0] ba,
  input logic [12:0] a,
  input logic [3:0] dqm_n,
  input logic [31:0] dq,
  output logic [31:0] dq_out = 32'h0
);
  logic [31:0] mem [bit [24:0]];
  logic [12:0] open_row [4];
  logic [31:0] rd_q;
  logic [24:0] k;
  int n = 9;
  // ----
  // Command sampling
  // ----
  always @(posedge clk)
  begin
    if (!sclk)
    begin
      k = {ba, open_row[ba], a[9:0]};
      n = (n < 9) ? n + 1 : 9;
      if (!cs_n && {ras_n, cas_n, we_n} == 3'h3)
        open_row[ba] = a;
      if (!cs_n && {ras_n, cas_n, we_n} == 3'h4)
      begin
        rd_q = mem.exists(k) ? mem[k] : 32'h0;
        for (int i = 0; i < 4; i++)
          if (!dqm_n[i]) rd_q[8*i +: 8] = dq[8*i +: 8];
        mem[k] = rd_q;
      end
      if (!cs_n && {ras_n, cas_n, we_n} == 3'h5)
      begin
        rd_q = mem.exists(k) ? mem[k] : 32'h0;
        n = 0;
      end
      dq_out <= (n == CL - 1 || n == CL) ? rd_q : ~dq_out;
    end
  end
endmodule // sdc_sdram_model

// ### testbench/tb_sdc_core.sv
// Bench of the SDRAM controller core
`timescale 1ns/1ps
module tb_sdc_core;
  logic clk = 0, rst = 1, awv = 0, wv = 0, bready = 0, arv = 0, rready = 0;
  logic mreq = 0, mwe = 0, oirq = 0;
  logic [7:0] awaddr = 0, araddr = 0;
  logic [31:0] wdata = 0, mwd = 0, rdat, v;
  logic [3:0] wstrb = 4'hf;
  logic [1:0] msz = 0, bresp, rresp, rs, lba;
  logic [27:0] maddr = 0;
  logic [2:0] lcmd;
  logic [12:0] la;
  wire awr, wr, bv, arr, rv, ack, mwait, sirq, mck, cke, cs_n, ras_n, cas_n, we_n, oe;
  wire [31:0] rd, mrd, dq, dqi;
  wire [1:0] ba;
  wire [12:0] ma;
  wire [3:0] dqm_n;
  int n_cmd = 0, n_act = 0, n_ref = 0, bad_count = 0, num_checks = 0, r0;
  sdc_core dut_u (
    .CORE_CLK(clk), .RST(rst), .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awv),
    .S_AXI_AWREADY(awr), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wv),
    .S_AXI_WREADY(wr), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bv), .S_AXI_BREADY(bready),
    .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arv), .S_AXI_ARREADY(arr), .S_AXI_RDATA(rd),
    .S_AXI_RRESP(rresp), .S_AXI_RVALID(rv), .S_AXI_RREADY(rready), .MEM_REQ(mreq),
    .MEM_WE(mwe), .MEM_SIZE(msz), .MEM_ADDR(maddr), .MEM_WDATA(mwd), .MEM_RDATA(mrd),
    .MEM_ACK(ack), .MEM_WAIT(mwait), .OTHER_IRQ(oirq), .SYS_IRQ(sirq),
    .MEM_CLOCK_OUT(mck), .MEM_CLOCK_ENABLE(cke), .MEM_CHIP_SELECT_N(cs_n),
    .MEM_ROW_STROBE_N(ras_n), .MEM_COL_STROBE_N(cas_n), .MEM_WRITE_ENABLE_N(we_n),
    .MEM_BANK(ba), .MEM_ADDR_BUS(ma), .BYTE_MASK_N(dqm_n), .DQ_IN(dqi), .DQ_OUT(dq),
    .DQ_OE(oe)
  );
  sdc_sdram_model #(.CL(2)) mdl_u (
    .clk(clk), .sclk(mck), .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n),
    .ba(ba), .a(ma), .dqm_n(dqm_n), .dq(dq), .dq_out(dqi)
  );
  initial forever #2.5 clk = ~clk;
  // ----
  // Monitor and tasks
  // ----
  always @(posedge clk)
  begin
    if (!mck && !cs_n && {ras_n, cas_n, we_n} != 3'h7)
    begin
      lcmd = {ras_n, cas_n, we_n};
      lba = ba;
      la = ma;
      n_cmd++;
      n_act += (lcmd == 3'h3);
      n_ref += (lcmd == 3'h1);
    end
  end
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic axw(input logic [7:0] ad, input logic [31:0] d);
    @(posedge clk);
    awaddr <= ad;
    wdata <= d;
    awv <= 1;
    wv <= 1;
    bready <= 1;
    do
    begin
      @(posedge clk);
      if (awr) awv <= 0;
      if (wr) wv <= 0;
    end
    while (!bv);
    bready <= 0;
  endtask
  task automatic axr(input logic [7:0] ad, output logic [31:0] d, output logic [1:0] r);
    @(posedge clk);
    araddr <= ad;
    arv <= 1;
    rready <= 1;
    do
    begin
      @(posedge clk);
      if (arr) arv <= 0;
    end
    while (!rv);
    d = rd;
    r = rresp;
    rready <= 0;
  endtask
  task automatic mem(input logic we, input logic [1:0] sz, input logic [27:0] ad,
    input logic [31:0] d);
    @(posedge clk);
    mreq <= 1;
    mwe <= we;
    msz <= sz;
    maddr <= ad;
    mwd <= d;
    do @(posedge clk);
    while (!ack);
    rdat = mrd;
    mreq <= 0;
  endtask
  task automatic close_out;
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  initial
  begin
    #400000;
    bad_count++;
    close_out;
  end
  // ----
  // Main sequence
  // ----
  initial
  begin
    repeat (6) @(posedge clk);
    rst <= 0;
    axr(8'h08, v, rs);
    chk("config", v, 32'h00072240);
    axr(8'h0c, v, rs);
    chk("unmapped", {v[29:0], rs}, 32'h2);
    repeat (40000) @(posedge clk);
    axw(8'h00, 32'h1);
    r0 = n_cmd;
    mem(1, 2'h2, 28'h0, 0);
    chk("nop", n_cmd - r0, 0);
    axw(8'h00, 32'h2);
    mem(1, 2'h2, 28'h0, 0);
    chk("pall", {lcmd, la[10]}, {3'h2, 1'b1});
    axw(8'h00, 32'h4);
    r0 = n_ref;
    repeat (8) mem(1, 2'h2, 28'h0, 0);
    chk("aref", n_ref - r0, 8);
    axw(8'h00, 32'h3);
    r0 = n_cmd;
    mem(1, 2'h2, 28'h0, 0);
    chk("lmr", {n_cmd - r0 == 1, lcmd, lba, la[6:0]}, {1'b1, 3'h0, 2'h0, 7'h20});
    axw(8'h00, 32'h5);
    mem(1, 2'h2, 28'h200000, 0);
    chk("emr", {lcmd, lba}, {3'h0, 2'h1});
    axw(8'h00, 32'h0);
    r0 = n_act;
    mem(1, 2'h2, 28'h40140c, 32'ha1b2c3d4);
    chk("wmap", {n_act - r0 == 1, lcmd, lba, la[7:0]}, {1'b1, 3'h4, 2'h2, 8'h03});
    mem(1, 2'h0, 28'h40140d, 32'h0000ee00);
    mem(1, 2'h1, 28'h40140e, 32'h99880000);
    r0 = n_act;
    mem(0, 2'h2, 28'h40140c, 0);
    chk("merge", rdat, 32'h9988eed4);
    chk("hit", n_act - r0, 0);
    r0 = n_act;
    mem(1, 2'h2, 28'h40180c, 32'h5);
    mem(0, 2'h2, 28'h40140c, 0);
    chk("miss", {n_act - r0 == 2, rdat}, {1'b1, 32'h9988eed4});
    axw(8'h14, 32'h1);
    axr(8'h1c, v, rs);
    chk("mask", v, 32'h1);
    oirq <= 1;
    repeat (3) @(posedge clk);
    chk("sysirq", sirq, 1);
    oirq <= 0;
    repeat (3) @(posedge clk);
    chk("sysirq", sirq, 0);
    axw(8'h04, 32'h64);
    r0 = n_ref;
    repeat (450) @(posedge clk);
    chk("refresh", n_ref - r0 >= 4, 1);
    mem(0, 2'h2, 28'h40180c, 0);
    chk("after", rdat, 32'h5);
    axr(8'h20, v, rs);
    chk("noerr", v, 0);
    close_out;
  end
endmodule // tb_sdc_core
bind sdc_core sdc_core_asserts chk_u (
  .CORE_CLK(CORE_CLK), .RST(RST), .MEM_ACK(MEM_ACK), .MEM_WAIT(MEM_WAIT),
  .OTHER_IRQ(OTHER_IRQ), .SYS_IRQ(SYS_IRQ), .MEM_CLOCK_ENABLE(MEM_CLOCK_ENABLE),
  .MEM_CHIP_SELECT_N(MEM_CHIP_SELECT_N), .MEM_ROW_STROBE_N(MEM_ROW_STROBE_N),
  .MEM_COL_STROBE_N(MEM_COL_STROBE_N), .MEM_WRITE_ENABLE_N(MEM_WRITE_ENABLE_N),
  .BYTE_MASK_N(BYTE_MASK_N), .DQ_OE(DQ_OE)
);
